// *** core/fcp_pkg.sv ***
// Notes on behaviour
// - Parameters locked while running; complete flag returns to one at finish.
// - Commands returning data place results in the parameter array.
// - Index 110 and 111 ignore writes and read as zero.
// - Word 0: code high byte, zero, address 22:16; word 1 address 15:0.
// - Erase verify section: code 0x03, address, phrase count at index 010.
// - Erase verify checks the range is erased, then sets complete flag.
// - Erase verify with index not 010 at launch sets access error.
// - Command not allowed in present mode sets access error.
// - Global address outside valid memory map sets access error.
// - Phrase address with low three bits nonzero sets access error.
// - Verify range crossing a 128 Kbyte boundary sets access error.
// - Any read error sets one flag; uncorrectable error sets another.
// - Read once reads a 64-byte, eight-phrase reserved field of block 0.
// - Read once: code 0x04, phrase index 0..7 at 001, data from 010.
// - Six 16-bit parameter words, three-bit index, byte access allowed.
package fcp_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_PARAM_HI = 4'h0;
    localparam logic [3:0] ADDR_PARAM_LO = 4'h1;
    localparam logic [3:0] ADDR_INDEX    = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_MODE     = 4'h6;
    // Status bit positions
    localparam int STAT_CCF  = 7;
    localparam int STAT_ACC  = 5;
    localparam int STAT_PV   = 4;
    localparam int STAT_RERR = 1;
    localparam int STAT_UERR = 0;
    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    // Command codes and indexes
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE    = 8'h04;
    localparam logic [2:0] IDX_CMD   = 3'h0;
    localparam logic [2:0] IDX_ADDR  = 3'h1;
    localparam logic [2:0] IDX_DATA0 = 3'h2;
    localparam logic [2:0] IDX_LAST  = 3'h5;
    localparam int NUM_WORDS = 6;
    // Address map limits
    localparam logic [22:0] PFLASH_BASE = 23'h700000;
    localparam int BOUNDARY_BIT = 17;
    localparam logic [15:0] ONCE_MAX_IDX = 16'h0007;
    localparam int ONCE_WORDS = 4;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // Reset values
    localparam logic [15:0] PARAM_RST = 16'h0000;
    localparam logic [1:0]  MASK_RST  = 2'h0;
endpackage : fcp_pkg

// *** core/fcp_range_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcp_range_check (
    input  wire logic [22:0] addr,
    input  wire logic [15:0] count,
    output logic             bad_addr,
    output logic             misaligned,
    output logic             crosses
);
    logic [23:0] last_byte;
    // Last byte covered: each phrase is eight bytes
    assign last_byte  = {1'b0, addr} + {5'h00, count, 3'h0} - 24'h000001;
    assign bad_addr   = (addr < fcp_pkg::PFLASH_BASE);
    assign misaligned = (addr[2:0] != 3'h0);
    assign crosses    = (count == 16'h0000) || last_byte[23]
                      || (last_byte[22:fcp_pkg::BOUNDARY_BIT]
                          != addr[22:fcp_pkg::BOUNDARY_BIT]);
endmodule : fcp_range_check
`default_nettype wire

// *** core/fcp_top.sv ***
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcp_top #(
    parameter int NUM_WORDS = fcp_pkg::NUM_WORDS
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // Flash array read port
    output logic             fl_rd,
    output logic [22:0]      fl_addr,
    input  wire logic        fl_valid,
    input  wire logic [15:0] fl_data,
    input  wire logic        fl_err,
    input  wire logic        fl_uerr,
    output logic             irq
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_READ  = 4'b0100,
        ST_WAIT  = 4'b1000
    } fcp_state_e;

    fcp_state_e  state_ff;
    logic [15:0] param_ff [NUM_WORDS];
    logic [2:0]  index_ff;
    logic        ccf_ff;
    logic        acc_ff;
    logic        rerr_ff;
    logic        uerr_ff;
    logic [1:0]  istat_ff;
    logic [1:0]  imask_ff;
    logic [1:0]  mode_ok_ff;
    logic [15:0] left_ff;
    logic [22:0] fl_addr_ff;
    logic [1:0]  word_ff;
    logic        launch;
    logic        launch_err;
    logic        done;
    logic        bad_addr;
    logic        misaligned;
    logic        crosses;
    logic [22:0] cmd_addr;
    logic [7:0]  cmd_code;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic idx_valid(input logic [2:0] idx);
        idx_valid = (idx <= fcp_pkg::IDX_LAST);
    endfunction : idx_valid

    assign cmd_code = param_ff[fcp_pkg::IDX_CMD][15:8];
    assign cmd_addr = {param_ff[fcp_pkg::IDX_CMD][6:0], param_ff[fcp_pkg::IDX_ADDR]};

    fcp_range_check u_range (
        .addr       (cmd_addr),
        .count      (param_ff[fcp_pkg::IDX_DATA0]),
        .bad_addr   (bad_addr),
        .misaligned (misaligned),
        .crosses    (crosses)
    );

    // Writing one to the complete flag while it is set launches a command
    assign launch = reg_wr && (reg_addr == fcp_pkg::ADDR_STATUS)
                 && reg_wdata[fcp_pkg::STAT_CCF] && ccf_ff;

    always_comb begin
        launch_err = 1'b0;
        unique case (cmd_code)
            fcp_pkg::CMD_ERASE_VERIFY: begin
                launch_err = (index_ff != fcp_pkg::IDX_DATA0)
                           || !mode_ok_ff[0]
                           || bad_addr || misaligned || crosses;
            end
            fcp_pkg::CMD_READ_ONCE: begin
                launch_err = !mode_ok_ff[1]
                   || (param_ff[fcp_pkg::IDX_ADDR] > fcp_pkg::ONCE_MAX_IDX);
            end
            default: launch_err = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_ff   <= ST_IDLE;
            left_ff    <= 16'h0000;
            fl_addr_ff <= 23'h000000;
            word_ff    <= 2'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: if (launch) begin
                    state_ff <= ST_CHECK;
                end
                ST_CHECK: begin
                    word_ff <= 2'h0;
                    if (launch_err) begin
                        state_ff <= ST_IDLE;
                    end else if (cmd_code == fcp_pkg::CMD_ERASE_VERIFY) begin
                        fl_addr_ff <= cmd_addr;
                        left_ff    <= param_ff[fcp_pkg::IDX_DATA0] << 2;
                        state_ff   <= ST_READ;
                    end else begin
                        // One-time field sits in block 0 information area
                        fl_addr_ff <= {13'h0000, param_ff[fcp_pkg::IDX_ADDR][2:0],
                                       6'h00, 1'b0};
                        left_ff    <= 16'(fcp_pkg::ONCE_WORDS);
                        state_ff   <= ST_READ;
                    end
                end
                ST_READ: state_ff <= ST_WAIT;
                ST_WAIT: if (fl_valid) begin
                    left_ff    <= left_ff - 16'h0001;
                    fl_addr_ff <= fl_addr_ff + 23'h000002;
                    word_ff    <= word_ff + 2'h1;
                    state_ff   <= (left_ff == 16'h0001) ? ST_IDLE : ST_READ;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign done    = ((state_ff == ST_CHECK) && launch_err)
                  || ((state_ff == ST_WAIT) && fl_valid && (left_ff == 16'h0001));
    assign fl_rd   = (state_ff == ST_READ);
    assign fl_addr = fl_addr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Parameter array
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                param_ff[i] <= fcp_pkg::PARAM_RST;
            end
        end else if ((state_ff == ST_WAIT) && fl_valid
                     && (cmd_code == fcp_pkg::CMD_READ_ONCE)) begin
            param_ff[3'(fcp_pkg::IDX_DATA0 + 3'(word_ff))] <= fl_data;
        end else if (reg_wr && ccf_ff && idx_valid(index_ff)) begin
            if (reg_addr == fcp_pkg::ADDR_PARAM_HI) begin
                param_ff[index_ff][15:8] <= reg_wdata;
            end else if (reg_addr == fcp_pkg::ADDR_PARAM_LO) begin
                param_ff[index_ff][7:0] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            index_ff   <= 3'h0;
            mode_ok_ff <= 2'h3;
        end else if (reg_wr && ccf_ff) begin
            if (reg_addr == fcp_pkg::ADDR_INDEX) begin
                index_ff <= reg_wdata[2:0];
            end
            if (reg_addr == fcp_pkg::ADDR_MODE) begin
                mode_ok_ff <= reg_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ccf_ff <= 1'b1;
        end else if (done) begin
            ccf_ff <= 1'b1;
        end else if (launch) begin
            ccf_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc_ff  <= 1'b0;
            rerr_ff <= 1'b0;
            uerr_ff <= 1'b0;
        end else begin
            if ((state_ff == ST_CHECK) && launch_err) begin
                acc_ff <= 1'b1;
            end else if (launch) begin
                acc_ff <= 1'b0;
            end
            // Only a verify treats a programmed word as a failure; read once data is free
            if ((state_ff == ST_WAIT) && fl_valid
                && (fl_err || fl_uerr || ((cmd_code == fcp_pkg::CMD_ERASE_VERIFY)
                                          && (fl_data != fcp_pkg::ERASED_WORD)))) begin
                rerr_ff <= 1'b1;
            end else if (launch) begin
                rerr_ff <= 1'b0;
            end
            if ((state_ff == ST_WAIT) && fl_valid && fl_uerr) begin
                uerr_ff <= 1'b1;
            end else if (launch) begin
                uerr_ff <= 1'b0;
            end
        end
    end

    // Sticky interrupt status; set wins over a write-one clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            istat_ff <= 2'h0;
            imask_ff <= fcp_pkg::MASK_RST;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == fcp_pkg::IRQ_DONE && done)
                    || (b == fcp_pkg::IRQ_ERR && (state_ff == ST_CHECK) && launch_err)) begin
                    istat_ff[b] <= 1'b1;
                end else if (reg_wr && (reg_addr == fcp_pkg::ADDR_IRQ_STAT)
                             && reg_wdata[b]) begin
                    istat_ff[b] <= 1'b0;
                end
            end
            if (reg_wr && (reg_addr == fcp_pkg::ADDR_IRQ_MASK)) begin
                imask_ff <= reg_wdata[1:0];
            end
        end
    end

    assign irq = |(istat_ff & imask_ff);

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                fcp_pkg::ADDR_PARAM_HI:
                    reg_rdata <= idx_valid(index_ff) ? param_ff[index_ff][15:8] : 8'h00;
                fcp_pkg::ADDR_PARAM_LO:
                    reg_rdata <= idx_valid(index_ff) ? param_ff[index_ff][7:0] : 8'h00;
                fcp_pkg::ADDR_INDEX:    reg_rdata <= {5'h00, index_ff};
                fcp_pkg::ADDR_STATUS:   reg_rdata <= {ccf_ff, 1'b0, acc_ff, 1'b0,
                                                      2'h0, rerr_ff, uerr_ff};
                fcp_pkg::ADDR_IRQ_STAT: reg_rdata <= {6'h00, istat_ff};
                fcp_pkg::ADDR_IRQ_MASK: reg_rdata <= {6'h00, imask_ff};
                fcp_pkg::ADDR_MODE:     reg_rdata <= {6'h00, mode_ok_ff};
                default:                reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_launch_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        launch |=> !ccf_ff) else $error("launch did not clear complete flag");
    chk_lock_params: assert property (@(posedge mclk) disable iff (!reset_n)
        (!ccf_ff && cmd_code == fcp_pkg::CMD_ERASE_VERIFY)
        |=> $stable(param_ff[fcp_pkg::IDX_DATA0]))
        else $error("parameter word changed while running");
    chk_index_lock: assert property (@(posedge mclk) disable iff (!reset_n)
        !ccf_ff |=> ($stable(index_ff) && $stable(mode_ok_ff)))
        else $error("index or mode changed while running");
    chk_err_fast_done: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_CHECK) && launch_err) |=> (ccf_ff && acc_ff))
        else $error("access error did not finish at once");
    chk_ev_index: assert property (@(posedge mclk) disable iff (!reset_n)
        (launch && cmd_code == fcp_pkg::CMD_ERASE_VERIFY
         && index_ff != fcp_pkg::IDX_DATA0) |=> ##1 acc_ff)
        else $error("bad index did not flag access error");
    chk_misaligned: assert property (@(posedge mclk) disable iff (!reset_n)
        (launch && cmd_code == fcp_pkg::CMD_ERASE_VERIFY && misaligned) |-> ##2 acc_ff)
        else $error("misaligned address not flagged");
    chk_uerr_read: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_WAIT) && fl_valid && fl_uerr) |=> (uerr_ff && rerr_ff))
        else $error("uncorrectable error not flagged");
    chk_unimpl_read: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_rd && reg_addr == fcp_pkg::ADDR_PARAM_HI && index_ff > fcp_pkg::IDX_LAST)
        |=> reg_rdata == 8'h00) else $error("unimplemented index read not zero");
    chk_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
        (istat_ff[0] && imask_ff[0]) |-> irq) else $error("irq not raised");
    cov_ev_ok: cover property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == ST_WAIT) && fl_valid && cmd_code == fcp_pkg::CMD_ERASE_VERIFY && done);
    cov_once: cover property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == ST_WAIT) && fl_valid && cmd_code == fcp_pkg::CMD_READ_ONCE && done);
    cov_acc: cover property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == ST_CHECK) && launch_err);
    cov_locked_write: cover property (@(posedge mclk) disable iff (!reset_n)
        !ccf_ff && reg_wr && (reg_addr == fcp_pkg::ADDR_PARAM_HI));
    cov_uerr: cover property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == ST_WAIT) && fl_valid && fl_uerr);

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and flag checks
    chk_launch_state: assert property (@(posedge mclk) disable iff (!reset_n)
        launch |=> (state_ff == ST_CHECK)) else $error("launch did not start a check");
    chk_ccf_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        ccf_ff |-> (state_ff == ST_IDLE)) else $error("complete flag set while busy");
    chk_ccf_done: assert property (@(posedge mclk) disable iff (!reset_n)
        done |=> ccf_ff) else $error("complete flag not set at finish");
    chk_flag_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        launch |=> (!acc_ff && !rerr_ff && !uerr_ff))
        else $error("flags not cleared at launch");
    chk_done_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        done |=> istat_ff[fcp_pkg::IRQ_DONE]) else $error("done not latched for interrupt");
    chk_err_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_CHECK) && launch_err) |=> istat_ff[fcp_pkg::IRQ_ERR])
        else $error("access error not latched for interrupt");
    chk_istat_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_wr && (reg_addr == fcp_pkg::ADDR_IRQ_STAT)
         && reg_wdata[fcp_pkg::IRQ_DONE] && !done)
        |=> !istat_ff[fcp_pkg::IRQ_DONE]) else $error("interrupt status not cleared");
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        !reg_rd |=> (reg_rdata == 8'h00)) else $error("read data stood past its cycle");
    chk_unimpl_lo: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_rd && reg_addr == fcp_pkg::ADDR_PARAM_LO && index_ff > fcp_pkg::IDX_LAST)
        |=> reg_rdata == 8'h00) else $error("unimplemented index read not zero");
    chk_param_write: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_wr && ccf_ff && reg_addr == fcp_pkg::ADDR_PARAM_LO
         && index_ff == fcp_pkg::IDX_DATA0)
        |=> (param_ff[fcp_pkg::IDX_DATA0][7:0] == $past(reg_wdata)))
        else $error("low byte write not taken");
    chk_mode_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (launch && cmd_code == fcp_pkg::CMD_ERASE_VERIFY && !mode_ok_ff[0]) |-> ##2 acc_ff)
        else $error("disallowed command not flagged");
    chk_range_err: assert property (@(posedge mclk) disable iff (!reset_n)
        (launch && cmd_code == fcp_pkg::CMD_ERASE_VERIFY && (bad_addr || crosses))
        |-> ##2 acc_ff) else $error("bad verify range not flagged");
    chk_once_range: assert property (@(posedge mclk) disable iff (!reset_n)
        (launch && cmd_code == fcp_pkg::CMD_READ_ONCE
         && param_ff[fcp_pkg::IDX_ADDR] > fcp_pkg::ONCE_MAX_IDX)
        |-> ##2 acc_ff) else $error("phrase index out of range not flagged");
    chk_rd_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
        fl_rd |=> !fl_rd) else $error("flash read strobe longer than a cycle");
    chk_ev_addr: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_CHECK) && !launch_err && cmd_code == fcp_pkg::CMD_ERASE_VERIFY)
        |=> (fl_addr == $past(cmd_addr))) else $error("verify start address wrong");
    chk_once_addr: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_CHECK) && !launch_err && cmd_code == fcp_pkg::CMD_READ_ONCE)
        |=> (fl_addr == {13'h0000, $past(param_ff[fcp_pkg::IDX_ADDR][2:0]), 7'h00}))
        else $error("read once address wrong");
    chk_wait_step: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_WAIT) && fl_valid && (left_ff != 16'h0001))
        |=> (fl_rd && (fl_addr == $past(fl_addr) + 23'h000002)))
        else $error("next flash word not requested");
    chk_rerr_data: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_WAIT) && fl_valid && cmd_code == fcp_pkg::CMD_ERASE_VERIFY
         && (fl_data != fcp_pkg::ERASED_WORD)) |=> rerr_ff)
        else $error("unerased word not flagged");
    chk_once_store: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state_ff == ST_WAIT) && fl_valid && cmd_code == fcp_pkg::CMD_READ_ONCE
         && (word_ff == 2'h0)) |=> (param_ff[fcp_pkg::IDX_DATA0] == $past(fl_data)))
        else $error("first read once word not stored");
endmodule : fcp_top
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [22:0] addr;
        logic [15:0] cnt;
        logic [2:0]  idx;
        logic [1:0]  mode;
        logic [7:0]  exp_st;
    } fcp_row_s;

    logic        mclk      = 1'b0;
    logic        reset_n   = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic        fl_rd;
    logic [22:0] fl_addr;
    logic        fl_valid  = 1'b0;
    logic [15:0] fl_data   = 16'h0000;
    logic        fl_err    = 1'b0;
    logic        fl_uerr   = 1'b0;
    logic        irq;
    int          errors    = 0;
    int          cmp_count = 0;
    int          rd_pulses = 0;
    int          p;
    logic [7:0]  rv;
    logic [15:0] w;
    fcp_row_s    rows [9];

    always #4 mclk = ~mclk;
    always @(posedge mclk) if (fl_rd === 1'b1) rd_pulses <= rd_pulses + 1;

    fcp_top fcp_top_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_valid(fl_valid), .fl_data(fl_data),
        .fl_err(fl_err), .fl_uerr(fl_uerr), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data only stand in the cycle after the strobe, so sample just past that edge
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task set_word(input logic [2:0] i, input logic [15:0] v);
        wr(fcp_pkg::ADDR_INDEX, {5'h00, i});
        wr(fcp_pkg::ADDR_PARAM_HI, v[15:8]);
        wr(fcp_pkg::ADDR_PARAM_LO, v[7:0]);
    endtask : set_word

    task get_word(input logic [2:0] i, output logic [15:0] v);
        wr(fcp_pkg::ADDR_INDEX, {5'h00, i});
        rd(fcp_pkg::ADDR_PARAM_HI, v[15:8]);
        rd(fcp_pkg::ADDR_PARAM_LO, v[7:0]);
    endtask : get_word

    task load(input logic [7:0] c, input logic [22:0] a, input logic [15:0] n,
              input logic [2:0] i);
        set_word(3'h0, {c, 1'b0, a[22:16]});
        set_word(3'h1, a[15:0]);
        set_word(3'h2, n);
        wr(fcp_pkg::ADDR_INDEX, {5'h00, i});
    endtask : load

    task wait_done(output logic [7:0] st);
        int n;
        for (n = 0; n < 20; n++) begin
            rd(fcp_pkg::ADDR_STATUS, st);
            if (st[fcp_pkg::STAT_CCF] === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            results();
        end
    endtask : wait_done

    // Answers n flash reads; kind 1 bad data, 2 any error, 3 uncorrectable, at word bad
    task serve(input int n, input int bad, input int kind, input bit chk,
               input logic [22:0] a0);
        int i;
        int t;
        for (i = 0; i < n; i++) begin
            for (t = 0; t < 30; t++) begin
                #1;
                if (fl_rd === 1'b1) break;
                @(posedge mclk);
            end
            if (t == 30) begin
                errors++;
                results();
            end
            check({1'b0, fl_addr}, {1'b0, a0 + 23'(2 * i)});
            // Slow answer on the first word gives room for a write while locked
            if (i == 0) wr(fcp_pkg::ADDR_PARAM_HI, 8'haa);
            @(posedge mclk);
            fl_valid <= 1'b1;
            fl_data  <= (i == bad && kind == 1) ? 16'h7fff :
                        (chk ? fcp_pkg::ERASED_WORD : 16'h1000 + 16'(i));
            fl_err   <= (i == bad && kind == 2);
            fl_uerr  <= (i == bad && kind == 3);
            @(posedge mclk);
            fl_valid <= 1'b0;
            fl_data  <= ~fl_data;
            fl_err   <= 1'b0;
            fl_uerr  <= 1'b0;
        end
    endtask : serve

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{8'h03, 23'h700000, 16'h0001, 3'h1, 2'h3, 8'ha0};
        rows[1] = '{8'h03, 23'h700000, 16'h0001, 3'h3, 2'h3, 8'ha0};
        rows[2] = '{8'h03, 23'h700000, 16'h0001, 3'h2, 2'h2, 8'ha0};
        rows[3] = '{8'h03, 23'h6ffff8, 16'h0001, 3'h2, 2'h3, 8'ha0};
        rows[4] = '{8'h03, 23'h700004, 16'h0001, 3'h2, 2'h3, 8'ha0};
        rows[5] = '{8'h03, 23'h71fff8, 16'h0002, 3'h2, 2'h3, 8'ha0};
        rows[6] = '{8'h05, 23'h700000, 16'h0001, 3'h2, 2'h3, 8'ha0};
        rows[7] = '{8'h04, 23'h000008, 16'h0000, 3'h2, 2'h3, 8'ha0};
        rows[8] = '{8'h04, 23'h000003, 16'h0000, 3'h2, 2'h1, 8'ha0};
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(fcp_pkg::ADDR_STATUS, rv);
        check({16'h0000, rv}, 24'h80);
        rd(fcp_pkg::ADDR_MODE, rv);
        check({16'h0000, rv}, 24'h03);
        rd(fcp_pkg::ADDR_IRQ_MASK, rv);
        check({16'h0000, rv}, 24'h00);
        check({23'h0, irq}, 24'h0);
        wr(4'hf, 8'hff);
        rd(fcp_pkg::ADDR_STATUS, rv);
        check({16'h0000, rv}, 24'h80);
        // Error rows never reach the flash port and finish at once
        for (int r = 0; r < 9; r++) begin
            wr(fcp_pkg::ADDR_MODE, {6'h00, rows[r].mode});
            load(rows[r].cmd, rows[r].addr, rows[r].cnt, rows[r].idx);
            p = rd_pulses;
            wr(fcp_pkg::ADDR_STATUS, 8'h80);
            wait_done(rv);
            check({16'h0000, rv}, {16'h0000, rows[r].exp_st});
            check(24'(rd_pulses - p), 24'h0);
            rd(fcp_pkg::ADDR_IRQ_STAT, rv);
            check({16'h0000, rv}, 24'h03);
            wr(fcp_pkg::ADDR_IRQ_STAT, 8'h03);
            rd(fcp_pkg::ADDR_IRQ_STAT, rv);
            check({16'h0000, rv}, 24'h00);
        end
        wr(fcp_pkg::ADDR_MODE, 8'h03);
        for (int k = 4; k < 8; k++) begin
            set_word(3'(k), 16'h1234);
            get_word(3'(k), w);
            check({8'h00, w}, (k < 6) ? 24'h1234 : 24'h0);
        end
        for (int k = 1; k < 4; k++) begin
            load(fcp_pkg::CMD_ERASE_VERIFY, 23'h700020, 16'h0001, 3'h2);
            wr(fcp_pkg::ADDR_STATUS, 8'h80);
            serve(4, k - 1, k, 1'b1, 23'h700020);
            wait_done(rv);
            check({16'h0000, rv}, (k == 3) ? 24'h83 : 24'h82);
        end
        check({23'h0, irq}, 24'h0);
        wr(fcp_pkg::ADDR_IRQ_STAT, 8'h03);
        wr(fcp_pkg::ADDR_IRQ_MASK, 8'h01);
        load(fcp_pkg::CMD_ERASE_VERIFY, 23'h700010, 16'h0002, 3'h2);
        wr(fcp_pkg::ADDR_STATUS, 8'h80);
        serve(8, 99, 0, 1'b1, 23'h700010);
        wait_done(rv);
        check({16'h0000, rv}, 24'h80);
        check({23'h0, irq}, 24'h1);
        get_word(3'h2, w);
        check({8'h00, w}, 24'h0002);
        wr(fcp_pkg::ADDR_IRQ_STAT, 8'h01);
        // The clear lands at the edge the write task returns on
        #1;
        check({23'h0, irq}, 24'h0);
        load(fcp_pkg::CMD_READ_ONCE, 23'h000005, 16'h0000, 3'h2);
        // Launched from the bench, never from the block that holds the field
        wr(fcp_pkg::ADDR_STATUS, 8'h80);
        serve(4, 99, 0, 1'b0, 23'h000280);
        wait_done(rv);
        check({16'h0000, rv}, 24'h80);
        for (int j = 0; j < 4; j++) begin
            get_word(3'(j + 2), w);
            check({8'h00, w}, 24'h1000 + 24'(j));
        end
        // Reset after the read once has finished returns the array and flags to their idle values
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        get_word(3'h2, w);
        check({8'h00, w}, 24'h0000);
        rd(fcp_pkg::ADDR_STATUS, rv);
        check({16'h0000, rv}, 24'h80);
        results();
    end
endmodule : tb_top
`default_nettype wire
